// ### hdl/jpd_consts.vh
// constants for the jtag programming data register block
`ifndef JPD_CONSTS_VH
`define JPD_CONSTS_VH
`define JPD_IR_W 4
`define JPD_IR_RESET 4'h0_00C
`define JPD_IR_UNLOCK 4'h0_004
`define JPD_IR_CMD 4'h0_005
`define JPD_IR_PLOAD 4'h0_006
`define JPD_IR_PREAD 4'h0_007
`define JPD_IR_RST_VAL 4'h0_00F
`define JPD_UNLOCK_W 16
`define JPD_SIGNATURE 16'hA370
`define JPD_CMD_W 15
`define JPD_BYTE_W 8
`define JPD_PC_W 16
`define JPD_TO_W 8
`define JPD_TAP_W 4
// tap state codes, standard encoding order chosen here
`define JPD_TLR 4'h0_000
`define JPD_RTI 4'h0_001
`define JPD_SEL_DR 4'h0_002
`define JPD_CAP_DR 4'h0_003
`define JPD_SHF_DR 4'h0_004
`define JPD_EX1_DR 4'h0_005
`define JPD_PAU_DR 4'h0_006
`define JPD_EX2_DR 4'h0_007
`define JPD_UPD_DR 4'h0_008
`define JPD_SEL_IR 4'h0_009
`define JPD_CAP_IR 4'h0_00A
`define JPD_SHF_IR 4'h0_00B
`define JPD_EX1_IR 4'h0_00C
`define JPD_PAU_IR 4'h0_00D
`define JPD_EX2_IR 4'h0_00E
`define JPD_UPD_IR 4'h0_00F
`define JPD_IR_CAPT 4'h0_001
`endif

// ### hdl/jpd_prog_regs.v
// jtag programming front end: tap, instruction and data registers
`timescale 1ns/100ps
`include "jpd_consts.vh"
// ----------------------------------------------------------------
// overview
// ----------------------------------------------------------------
// this block sits behind the four test pins and holds the tap
// controller, the instruction register and the programming data
// registers: the one-bit reset bit, the 16-bit unlock register,
// the 15-bit command register and the 8-bit page data byte, which
// is simply the low byte of the command register.
//
// clocking
// everything runs on the core clock; tck is only a pin that gets
// sampled. tck, tms and tdi each pass two flip-flops, and a rising
// or falling tck is found by comparing the synchronised level with
// the value one core clock older. the practical limit is that a
// tck half period must span at least three core clocks, otherwise
// edges are merged or lost. a faster link would need a real tck
// domain, which was traded away for a single clock and simple
// timing closure.
//
// tap controller
// the usual sixteen states, advanced on each detected tck rise,
// with tms taken from its synchroniser. since tms and tck share
// the same synchroniser depth, the tms level seen at a detected
// rise is the level the pin had when that rise was first sampled.
//
// instruction register
// four bits, shifted lsb first in shift-ir and captured as the
// fixed pattern 0001 in capture-ir. test-logic-reset loads the
// bypass code, so unknown codes and the reset default both select
// the one-bit bypass path.
//
// reset bit
// shifted directly, with no update stage, so the part enters reset
// on the very tck rise that shifts a one in. release is stretched
// by the time-out count taken from the time-out input, counted in
// core clocks. the reset code does not reset the tap itself.
//
// unlock register
// sixteen bits, lsb first. at update-dr under the unlock code the
// contents are compared with the signature and programming mode is
// entered on an exact match only. mode is dropped as soon as the
// register no longer holds the signature, so shifting a new value
// in ends programming mode straight away.
//
// command register
// capture-dr loads the result of the previous command, shift-dr
// moves that result out on tdo while the new command enters, and
// update-dr applies the command to the array inputs. every tck rise
// spent in run-test/idle under the command code gives one execute
// strobe. a hazard for the user: idle rises before a data scan
// also strobe, as the array expects an execute clock per idle tck.
//
// page load and page read
// both use the low command byte as an eight-bit data register.
// page load writes at each update-dr, alternating low then high
// byte from the first update after the code is entered, and steps
// the program counter before every low byte except the first. page
// read captures at each capture-dr, alternating in the same way,
// and steps the counter after every high byte, the first included.
//
// program counter
// the counter is preset from the low byte of an applied command one
// core clock after the command strobe. the preset clears the high
// address byte, and increments carry on through all sixteen bits.
//
// tdo
// tdo and its enable change on detected tck falls, so the far end
// can sample on its own next rise. the enable is low only in the
// two shift states; elsewhere the pin is released.
//
// clock enable
// a low clock enable freezes every register, synchronisers included,
// so a tck edge that arrives while frozen is seen late, and a pulse that ends while frozen is missed.
module jpd_prog_regs (
    input wire core_clk_in,
    input wire reset_n_in,
    input wire clk_en_in,
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    input wire [`JPD_TO_W-1:0] reset_timeout_in,
    input wire [`JPD_CMD_W-1:0] cmd_result_in,
    input wire [`JPD_BYTE_W-1:0] flash_low_in,
    input wire [`JPD_BYTE_W-1:0] flash_high_in,
    output reg tdo_out,
    output reg tdo_oe_n_out,
    output reg part_reset_out,
    output reg prog_mode_out,
    output reg [`JPD_CMD_W-1:0] cmd_out,
    output reg cmd_clk_out,
    output reg [`JPD_BYTE_W-1:0] page_data_out,
    output reg page_high_out,
    output reg page_wr_out,
    output reg [`JPD_PC_W-1:0] pc_out,
    output reg pc_load_out
);
// ----------------------------------------------------------------
// pin synchronisers and tck edge detect
// ----------------------------------------------------------------
reg [1:0] tck_sync_reg;
reg [1:0] tms_sync_reg;
reg [1:0] tdi_sync_reg;
reg tck_prev_reg;
wire tck_rise = tck_sync_reg[1] & ~tck_prev_reg;
wire tck_fall = ~tck_sync_reg[1] & tck_prev_reg;
wire tms_s = tms_sync_reg[1];
wire tdi_s = tdi_sync_reg[1];
// second stage only is read, first stage feeds nothing else
always @(posedge core_clk_in) begin
    if (!reset_n_in) begin
        tck_sync_reg <= 2'b00;
        tms_sync_reg <= 2'b11;
        tdi_sync_reg <= 2'b00;
        tck_prev_reg <= 1'b0;
    end else if (clk_en_in) begin
        tck_sync_reg <= {tck_sync_reg[0], tck_in};
        tms_sync_reg <= {tms_sync_reg[0], tms_in};
        tdi_sync_reg <= {tdi_sync_reg[0], tdi_in};
        tck_prev_reg <= tck_sync_reg[1];
    end
end
// ----------------------------------------------------------------
// tap controller
// ----------------------------------------------------------------
reg [`JPD_TAP_W-1:0] tap_reg;
reg [`JPD_TAP_W-1:0] tap_next;
always @* begin
    tap_next = tap_reg;
    case (tap_reg)
        `JPD_TLR: tap_next = tms_s ? `JPD_TLR : `JPD_RTI;
        `JPD_RTI: tap_next = tms_s ? `JPD_SEL_DR : `JPD_RTI;
        `JPD_SEL_DR: tap_next = tms_s ? `JPD_SEL_IR : `JPD_CAP_DR;
        `JPD_CAP_DR: tap_next = tms_s ? `JPD_EX1_DR : `JPD_SHF_DR;
        `JPD_SHF_DR: tap_next = tms_s ? `JPD_EX1_DR : `JPD_SHF_DR;
        `JPD_EX1_DR: tap_next = tms_s ? `JPD_UPD_DR : `JPD_PAU_DR;
        `JPD_PAU_DR: tap_next = tms_s ? `JPD_EX2_DR : `JPD_PAU_DR;
        `JPD_EX2_DR: tap_next = tms_s ? `JPD_UPD_DR : `JPD_SHF_DR;
        `JPD_UPD_DR: tap_next = tms_s ? `JPD_SEL_DR : `JPD_RTI;
        `JPD_SEL_IR: tap_next = tms_s ? `JPD_TLR : `JPD_CAP_IR;
        `JPD_CAP_IR: tap_next = tms_s ? `JPD_EX1_IR : `JPD_SHF_IR;
        `JPD_SHF_IR: tap_next = tms_s ? `JPD_EX1_IR : `JPD_SHF_IR;
        `JPD_EX1_IR: tap_next = tms_s ? `JPD_UPD_IR : `JPD_PAU_IR;
        `JPD_PAU_IR: tap_next = tms_s ? `JPD_EX2_IR : `JPD_PAU_IR;
        `JPD_EX2_IR: tap_next = tms_s ? `JPD_UPD_IR : `JPD_SHF_IR;
        `JPD_UPD_IR: tap_next = tms_s ? `JPD_SEL_DR : `JPD_RTI;
        default: tap_next = `JPD_TLR;
    endcase
end
// ----------------------------------------------------------------
// instruction and data registers, all acting on tck rising edge
// ----------------------------------------------------------------
reg [`JPD_IR_W-1:0] ir_shift_reg;
reg [`JPD_IR_W-1:0] ir_reg;
reg reset_bit_reg;
reg [`JPD_UNLOCK_W-1:0] unlock_reg;
reg [`JPD_CMD_W-1:0] cmd_shift_reg;
reg bypass_reg;
reg load_high_reg;
reg load_first_reg;
reg read_high_reg;
reg [`JPD_TO_W-1:0] timeout_cnt_reg;
// in a given state these say what happens on this tck rise
wire in_cap = (tap_reg == `JPD_CAP_DR);
wire in_shf = (tap_reg == `JPD_SHF_DR);
wire in_upd = (tap_reg == `JPD_UPD_DR);
wire sel_rst = (ir_reg == `JPD_IR_RESET);
wire sel_unl = (ir_reg == `JPD_IR_UNLOCK);
wire sel_cmd = (ir_reg == `JPD_IR_CMD);
wire sel_pld = (ir_reg == `JPD_IR_PLOAD);
wire sel_prd = (ir_reg == `JPD_IR_PREAD);
wire sel_byte = sel_pld | sel_prd;
always @(posedge core_clk_in) begin
    if (!reset_n_in) begin
        tap_reg <= `JPD_TLR;
        ir_shift_reg <= `JPD_IR_RST_VAL;
        ir_reg <= `JPD_IR_RST_VAL;
        reset_bit_reg <= 1'b0;
        unlock_reg <= {`JPD_UNLOCK_W{1'b0}};
        cmd_shift_reg <= {`JPD_CMD_W{1'b0}};
        bypass_reg <= 1'b0;
        load_high_reg <= 1'b0;
        load_first_reg <= 1'b1;
        read_high_reg <= 1'b0;
        cmd_out <= {`JPD_CMD_W{1'b0}};
        cmd_clk_out <= 1'b0;
        page_data_out <= {`JPD_BYTE_W{1'b0}};
        page_high_out <= 1'b0;
        page_wr_out <= 1'b0;
        pc_out <= {`JPD_PC_W{1'b0}};
        pc_load_out <= 1'b0;
    end else if (clk_en_in) begin
        // strobes last one core clock
        cmd_clk_out <= 1'b0;
        page_wr_out <= 1'b0;
        pc_load_out <= 1'b0;
        if (tck_rise) begin
            tap_reg <= tap_next;
            // the reset instruction does not touch the tap itself
            if (tap_reg == `JPD_TLR) begin
                ir_reg <= `JPD_IR_RST_VAL;
            end
            if (tap_reg == `JPD_CAP_IR) begin
                ir_shift_reg <= `JPD_IR_CAPT;
            end else if (tap_reg == `JPD_SHF_IR) begin
                ir_shift_reg <= {tdi_s, ir_shift_reg[`JPD_IR_W-1:1]};
            end else if (tap_reg == `JPD_UPD_IR) begin
                ir_reg <= ir_shift_reg;
                // a new instruction restarts byte alternation
                load_high_reg <= 1'b0;
                load_first_reg <= 1'b1;
                read_high_reg <= 1'b0;
            end
            // reset bit drives reset straight from the shift stage
            if (in_shf && sel_rst) begin
                reset_bit_reg <= tdi_s;
            end
            if (in_shf && sel_unl) begin
                unlock_reg <= {tdi_s, unlock_reg[`JPD_UNLOCK_W-1:1]};
            end
            if (in_shf && !(sel_rst || sel_unl || sel_cmd || sel_byte)) begin
                bypass_reg <= tdi_s;
            end
            // command register capture and shift
            if (in_cap && sel_cmd) begin
                cmd_shift_reg <= cmd_result_in;
            end else if (in_cap && sel_prd) begin
                cmd_shift_reg[`JPD_BYTE_W-1:0] <=
                    read_high_reg ? flash_high_in : flash_low_in;
                read_high_reg <= ~read_high_reg;
                if (read_high_reg) begin
                    pc_out <= pc_out + 16'h0001;
                end
            end else if (in_shf && sel_cmd) begin
                cmd_shift_reg <= {tdi_s, cmd_shift_reg[`JPD_CMD_W-1:1]};
            end else if (in_shf && sel_byte) begin
                cmd_shift_reg[`JPD_BYTE_W-1:0] <=
                    {tdi_s, cmd_shift_reg[`JPD_BYTE_W-1:1]};
            end
            // update: apply command or write a page byte
            if (in_upd && sel_cmd) begin
                cmd_out <= cmd_shift_reg;
                pc_load_out <= 1'b1;
            end else if (in_upd && sel_pld) begin
                page_data_out <= cmd_shift_reg[`JPD_BYTE_W-1:0];
                page_high_out <= load_high_reg;
                page_wr_out <= 1'b1;
                load_high_reg <= ~load_high_reg;
                load_first_reg <= 1'b0;
                if (!load_high_reg && !load_first_reg) begin
                    pc_out <= pc_out + 16'h0001;
                end
            end
            // each idle tck gives one execute clock under commands
            if (tap_reg == `JPD_RTI && sel_cmd) begin
                cmd_clk_out <= 1'b1;
            end
        end
        // address preset taken from the applied command field
        if (pc_load_out) begin
            pc_out <= {8'h00, cmd_out[`JPD_BYTE_W-1:0]};
        end
    end
end
// ----------------------------------------------------------------
// tdo on falling tck, reset stretch and programming enable
// ----------------------------------------------------------------
always @(posedge core_clk_in) begin
    if (!reset_n_in) begin
        tdo_out <= 1'b0;
        tdo_oe_n_out <= 1'b1;
        part_reset_out <= 1'b0;
        prog_mode_out <= 1'b0;
        timeout_cnt_reg <= {`JPD_TO_W{1'b0}};
    end else if (clk_en_in) begin
        if (tck_fall) begin
            tdo_oe_n_out <= ~((tap_reg == `JPD_SHF_DR) || (tap_reg == `JPD_SHF_IR));
            if (tap_reg == `JPD_SHF_IR) begin
                tdo_out <= ir_shift_reg[0];
            end else if (sel_rst) begin
                tdo_out <= reset_bit_reg;
            end else if (sel_unl) begin
                tdo_out <= unlock_reg[0];
            end else if (sel_cmd || sel_byte) begin
                tdo_out <= cmd_shift_reg[0];
            end else begin
                tdo_out <= bypass_reg;
            end
        end
        // reset holds while the bit is one, then for the time-out
        if (reset_bit_reg) begin
            part_reset_out <= 1'b1;
            timeout_cnt_reg <= reset_timeout_in;
        end else if (timeout_cnt_reg != {`JPD_TO_W{1'b0}}) begin
            timeout_cnt_reg <= timeout_cnt_reg - 8'h01;
        end else begin
            part_reset_out <= 1'b0;
        end
        // enable set at unlock update-dr on a signature match, dropped whenever the register differs
        if (tck_rise && in_upd && sel_unl) begin
            prog_mode_out <= (unlock_reg == `JPD_SIGNATURE);
        end else if (unlock_reg != `JPD_SIGNATURE) begin
            prog_mode_out <= 1'b0;
        end
    end
end
endmodule // jpd_prog_regs

// ### test/jpd_prog_model.sv
// jtag programmer model driving the tap pins
`timescale 1ns/100ps
module jpd_prog_model (
    output reg tck_out,
    output reg tms_out,
    output reg tdi_out,
    input wire tdo_in
);
// ----------------------------------------
// tap sequencing
// ----------------------------------------
reg tdo_seen;
initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
end
// one 320 ns tck; tdo is taken late in the high phase because the
// core needs up to three of its clocks to move it after the fall
task step(input reg tms, input reg tdi);
    begin
        tms_out = tms;
        tdi_out = tdi;
        #160 tck_out = 1'b1;
        #150 tdo_seen = tdo_in;
        #10 tck_out = 1'b0;
    end
endtask
// five ones reach test-logic-reset from anywhere, then park in idle
task tap_reset;
    integer i;
    begin
        for (i = 0; i < 5; i = i + 1) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    end
endtask
// idle to idle scan of the instruction or a data register
task scan(input reg ir, input integer n, input reg [15:0] din, output reg [15:0] dout);
    integer i;
    begin
        dout = 16'h0000;
        step(1'b1, 1'b0);
        if (ir) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        for (i = 0; i < n; i = i + 1) begin
            step(i == n - 1, din[i]);
            dout[i] = tdo_seen;
        end
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    end
endtask
endmodule // jpd_prog_model

// ### test/jpd_prog_properties.sv
// assertion checker for the jtag programming front end
`timescale 1ns/100ps
`include "jpd_consts.vh"
module jpd_prog_chk (
    input wire core_clk_in,
    input wire reset_n_in,
    input wire [`JPD_TO_W-1:0] reset_timeout_in,
    input wire tdo_oe_n_out,
    input wire part_reset_out,
    input wire prog_mode_out,
    input wire [`JPD_CMD_W-1:0] cmd_out,
    input wire cmd_clk_out,
    input wire page_high_out,
    input wire page_wr_out,
    input wire [`JPD_PC_W-1:0] pc_out,
    input wire pc_load_out
);
default clocking @(posedge core_clk_in); endclocking
default disable iff (!reset_n_in);
// ----------------------------------------
// helper state and properties
// ----------------------------------------
reg low_seen_reg;
reg [15:0] hold_cnt_reg;
// last write lane, and how long the part has been held in reset
always @(posedge core_clk_in) begin
    if (!reset_n_in) begin
        low_seen_reg <= 1'b0;
        hold_cnt_reg <= 16'h0000;
    end else begin
        if (page_wr_out) low_seen_reg <= !page_high_out;
        hold_cnt_reg <= part_reset_out ? hold_cnt_reg + 16'h0001 : 16'h0000;
    end
end
a_reset_vals: assert property ($rose(reset_n_in) |-> tdo_oe_n_out && !prog_mode_out)
    else $error("outputs not at reset values");
a_wr_one_cycle: assert property (page_wr_out |=> !page_wr_out)
    else $error("page write strobe too long");
a_cmdclk_one_cycle: assert property (cmd_clk_out |-> ##1 !cmd_clk_out)
    else $error("command clock too long");
a_pcload_one_cycle: assert property (pc_load_out ##1 pc_load_out |-> 1'b0)
    else $error("pc load strobe too long");
a_pc_preset: assert property (pc_load_out |=> pc_out == {8'h00, cmd_out[7:0]})
    else $error("pc not preset from command");
a_cmd_then_load: assert property ($changed(cmd_out) |-> ##[0:2] pc_load_out)
    else $error("command applied without pc load");
a_high_after_low: assert property (page_wr_out && page_high_out |-> low_seen_reg)
    else $error("high byte written without low byte");
a_reset_stretch: assert property ($fell(part_reset_out) |->
    hold_cnt_reg >= {8'h00, reset_timeout_in}) else $error("reset released early");
c_high_wr: cover property (page_wr_out && page_high_out);
c_cmd_clk: cover property (cmd_clk_out);
c_reset_end: cover property ($fell(part_reset_out));
endmodule // jpd_prog_chk
bind jpd_prog_regs jpd_prog_chk i_chk (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .reset_timeout_in(reset_timeout_in), .tdo_oe_n_out(tdo_oe_n_out),
    .part_reset_out(part_reset_out), .prog_mode_out(prog_mode_out), .cmd_out(cmd_out),
    .cmd_clk_out(cmd_clk_out), .page_high_out(page_high_out), .page_wr_out(page_wr_out),
    .pc_out(pc_out), .pc_load_out(pc_load_out));

// ### test/testbench.sv
// self-checking bench for the jtag programming front end
`timescale 1ns/100ps
module testbench;
reg core_clk_in = 1'b0;
reg reset_n_in = 1'b0;
reg clk_en_in = 1'b1;
reg [7:0] reset_timeout_in = 8'h40;
reg [14:0] cmd_result_in = 15'h0000;
reg [7:0] flash_low_in = 8'h3C;
reg [7:0] flash_high_in = 8'hC3;
wire tck, tms, tdi, tdo, tdo_oe_n, tdo_line, part_reset, prog_mode;
wire cmd_clk, page_high, page_wr, pc_load;
wire [14:0] cmd;
wire [7:0] page_data;
wire [15:0] pc;
integer bad_count = 0;
integer checks_done = 0;
integer wr_n = 0;
integer clk_n = 0;
integer k;
reg rst_seen = 1'b0;
reg [15:0] dout;
reg [16:0] wr_log [0:7];
// ----------------------------------------
// clock, dut, programmer and monitors
// ----------------------------------------
always #20 core_clk_in = ~core_clk_in;
// an undriven tdo shows the inverse so a stale bit cannot pass
assign tdo_line = tdo_oe_n ? ~tdo : tdo;
jpd_prog_regs i_dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .reset_timeout_in(reset_timeout_in),
    .cmd_result_in(cmd_result_in), .flash_low_in(flash_low_in), .flash_high_in(flash_high_in),
    .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .part_reset_out(part_reset),
    .prog_mode_out(prog_mode), .cmd_out(cmd), .cmd_clk_out(cmd_clk), .page_data_out(page_data),
    .page_high_out(page_high), .page_wr_out(page_wr), .pc_out(pc), .pc_load_out(pc_load));
jpd_prog_model i_prog (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_line));
// log page writes and count strobes as they happen
always @(posedge core_clk_in) begin
    if (page_wr) wr_log[wr_n % 8] = {page_high, page_data, pc[7:0]};
    if (page_wr) wr_n = wr_n + 1;
    if (cmd_clk) clk_n = clk_n + 1;
    if (part_reset) rst_seen = 1'b1;
end
task chk(input reg [23:0] seen, input reg [23:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp) bad_count = bad_count + 1;
        if (seen !== exp) $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
endtask
task end_sim;
    begin
        if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end
endtask
// a hang is cut short well after the expected run of about 95 us
initial begin
    #2000000;
    bad_count = bad_count + 1;
    end_sim;
end
initial begin
    repeat (6) @(posedge core_clk_in);
    #1 reset_n_in = 1'b1;
    i_prog.tap_reset;
    i_prog.scan(1'b1, 4, 16'h000C, dout);
    chk(dout, 16'h0001);
    i_prog.scan(1'b0, 2, 16'h0001, dout);
    chk(rst_seen, 1'b1);
    chk(part_reset, 1'b1);
    repeat (100) @(posedge core_clk_in);
    chk(part_reset, 1'b0);
    i_prog.scan(1'b0, 1, 16'h0001, dout);
    repeat (100) @(posedge core_clk_in);
    chk(part_reset, 1'b1);
    i_prog.scan(1'b1, 4, 16'h0004, dout);
    i_prog.scan(1'b0, 16, 16'hA371, dout);
    chk(prog_mode, 1'b0);
    i_prog.scan(1'b0, 16, 16'hA370, dout);
    chk(prog_mode, 1'b1);
    @(posedge core_clk_in) #1 cmd_result_in = 15'h2A5B;
    i_prog.scan(1'b1, 4, 16'h0005, dout);
    i_prog.scan(1'b0, 15, 16'h0A5C, dout);
    chk(dout, 16'h2A5B);
    chk(cmd, 15'h0A5C);
    chk(pc, 16'h005C);
    // earlier idle rises under the command code pulse too, so count only these two
    k = clk_n;
    i_prog.step(1'b0, 1'b0);
    i_prog.step(1'b0, 1'b0);
    chk(clk_n - k, 2);
    i_prog.scan(1'b1, 4, 16'h0006, dout);
    for (k = 0; k < 4; k = k + 1) begin
        i_prog.scan(1'b0, 8, 16'h0010 + k, dout);
        chk(wr_n, k + 1);
        chk(wr_log[k], {k[0], k[7:0] + 8'h10, k[8:1] + 8'h5C});
    end
    i_prog.scan(1'b1, 4, 16'h0007, dout);
    for (k = 0; k < 4; k = k + 1) begin
        i_prog.scan(1'b0, 8, 16'h0000, dout);
        chk(dout, k[0] ? 16'h00C3 : 16'h003C);
        chk(pc, 16'h005D + ((k + 1) >> 1));
    end
    i_prog.scan(1'b1, 4, 16'h0004, dout);
    i_prog.scan(1'b0, 16, 16'h0000, dout);
    chk(prog_mode, 1'b0);
    end_sim;
end
endmodule // testbench
